/* sbf_store_buffer.sv */
// store buffer that forwards local writes to later local reads
//
// Behaviour
// RQ1: forward buffered data to unordered or acquire reads
// RQ2: forwarding keeps all local ordering constraints
// RQ3: same-address accesses resolved in program order
// RQ4: reads may pass earlier writes to other addresses
// RQ5: local visibility never after global visibility
// RQ6: write locally visible before any read returning it
// RQ7: no forwarding across an intervening ordering operation
// RQ8: barrier visible only after all earlier writes
// RQ9: visible barrier means earlier writes globally visible
// RQ10: acquire read precedes every later memory operation
// RQ11: release write does not order later reads
// RQ12: local visibility does not order remote observation
// RQ13: local dependency creates no remote ordering
// RQ14: overlapping different-size accesses may look non-atomic
// RQ15: no forwarding into or from semaphore operations
// RQ16: entries before a barrier block forwarding until drained
`timescale 1ns/100ps
`default_nettype none
`include "sbf_cfg.svh"

module sbf_store_buffer #(
    parameter int DEPTH = `SBF_DEPTH
) (
    // clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst_n,
    // request stream from the local pipeline, in program order
    input  wire logic                 i_req_valid,
    input  wire sbf_pkg::sbf_req_s    i_req,
    output logic                      o_req_ready,
    // read answer to the local pipeline
    output logic                      o_rsp_valid,
    output logic [`SBF_DW-1:0]        o_rsp_data,
    output logic                      o_rsp_fwd,
    // barrier completion
    output logic                      o_bar_done,
    // read port to the coherence domain
    output logic                      o_mem_rd_valid,
    output logic [`SBF_AW-1:0]        o_mem_rd_addr,
    input  wire logic                 i_mem_rd_ack,
    input  wire logic [`SBF_DW-1:0]   i_mem_rd_data,
    // drain port: ack marks the global visibility point
    output logic                      o_drain_valid,
    output sbf_pkg::sbf_write_s       o_drain,
    input  wire logic                 i_drain_ack
);

    localparam int IW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////////
    // state
    sbf_pkg::sbf_entry_s    ent_r   [DEPTH];
    sbf_pkg::sbf_entry_s    ent_nxt [DEPTH];
    logic [IW-1:0]          head_r, head_nxt;
    logic [CW-1:0]          count_r, count_nxt;
    sbf_pkg::sbf_ld_state_e st_r, st_nxt;
    sbf_pkg::sbf_req_s      ld_r, ld_nxt;
    logic                   bar_wait_r, bar_wait_nxt;
    logic                   req_ready_r, req_ready_nxt;
    logic                   rsp_valid_r, rsp_valid_nxt;
    logic [`SBF_DW-1:0]     rsp_data_r, rsp_data_nxt;
    logic                   rsp_fwd_r, rsp_fwd_nxt;
    logic                   bar_done_r, bar_done_nxt;
    logic                   mem_rd_r, mem_rd_nxt;
    logic                   drain_valid_r, drain_valid_nxt;
    sbf_pkg::sbf_write_s    drain_r, drain_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // search of buffered writes for the held read
    logic                   any_fence;
    logic                   hit;
    logic [IW-1:0]          hit_idx;
    logic [IW-1:0]          idx;
    sbf_pkg::sbf_entry_s    yng;
    logic                   full_cov;

    always_comb begin
        any_fence = 1'b0;
        hit       = 1'b0;
        hit_idx   = '0;
        idx       = '0;
        for (int i = 0; i < DEPTH; i++) begin
            idx = head_r + IW'(i);
            if (ent_r[idx].vld) begin
                any_fence = any_fence | ent_r[idx].fence;
                // oldest to youngest, so the last overlap is the newest write
                if ((ent_r[idx].wr.addr[`SBF_AW-1:`SBF_LANE_LSB] == ld_r.addr[`SBF_AW-1:`SBF_LANE_LSB])
                    && ((ent_r[idx].wr.be & ld_r.be) != '0)) begin // [RQ3]
                    hit     = 1'b1;
                    hit_idx = idx;
                end
            end
        end
        yng   = ent_r[hit_idx];
        full_cov = ((yng.wr.be & ld_r.be) == ld_r.be);
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    logic                   take;
    logic                   is_wr;
    logic                   is_rd;
    logic                   pop;
    logic [IW-1:0]          tail;
    logic [`SBF_DW-1:0]     merged;

    always_comb begin
        take          = i_req_valid & req_ready_r;
        is_wr         = (i_req.op == sbf_pkg::SBF_UNORDERED_WRITE) ||
                        (i_req.op == sbf_pkg::SBF_RELEASE_WRITE) ||
                        (i_req.op == sbf_pkg::SBF_SEMAPHORE_WRITE);
        is_rd         = (i_req.op == sbf_pkg::SBF_UNORDERED_READ) ||
                        (i_req.op == sbf_pkg::SBF_ACQUIRE_READ) ||
                        (i_req.op == sbf_pkg::SBF_SEMAPHORE_READ);
        pop           = drain_valid_r & i_drain_ack;
        tail          = head_r + count_r[IW-1:0];
        merged        = '0;
        for (int i = 0; i < DEPTH; i++) begin
            ent_nxt[i] = ent_r[i];
        end
        head_nxt      = head_r;
        count_nxt     = count_r;
        st_nxt        = st_r;
        ld_nxt        = ld_r;
        bar_wait_nxt  = bar_wait_r;
        rsp_valid_nxt = 1'b0;
        rsp_data_nxt  = rsp_data_r;
        rsp_fwd_nxt   = rsp_fwd_r;
        bar_done_nxt  = 1'b0;
        mem_rd_nxt    = mem_rd_r;

        // global visibility: drain strictly oldest first
        if (pop) begin // [RQ12] [RQ13]
            ent_nxt[head_r].vld   = 1'b0;
            ent_nxt[head_r].fence = 1'b0;
            head_nxt              = head_r + IW'(1);
        end

        if (take && is_wr) begin
            // entry is locally visible from the cycle after acceptance
            ent_nxt[tail].vld   = 1'b1; // [RQ5] [RQ6]
            ent_nxt[tail].sem   = (i_req.op == sbf_pkg::SBF_SEMAPHORE_WRITE);
            ent_nxt[tail].fence = 1'b0;
            ent_nxt[tail].wr    = '{addr: i_req.addr, data: i_req.data, be: i_req.be};
        end
        count_nxt = count_r + CW'(take && is_wr) - CW'(pop);

        // barrier completes once every earlier write is drained
        if (bar_wait_r && !any_fence) begin // [RQ8] [RQ9]
            bar_wait_nxt = 1'b0;
            bar_done_nxt = 1'b1;
        end

        // a new barrier in the completion cycle keeps its wait
        if (take && (i_req.op == sbf_pkg::SBF_ORDERING_BARRIER)) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (ent_r[i].vld) begin
                    ent_nxt[i].fence = 1'b1; // [RQ16]
                end
            end
            bar_wait_nxt = 1'b1;
        end

        case (st_r)
            sbf_pkg::SBF_LD_IDLE: begin
                if (take && is_rd) begin
                    ld_nxt = i_req;
                    st_nxt = sbf_pkg::SBF_LD_HOLD;
                end
            end
            sbf_pkg::SBF_LD_HOLD: begin
                if (any_fence) begin
                    st_nxt = sbf_pkg::SBF_LD_HOLD; // [RQ7] [RQ8]
                end else if (ld_r.op == sbf_pkg::SBF_SEMAPHORE_READ) begin
                    if (!hit) begin // [RQ15]
                        st_nxt     = sbf_pkg::SBF_LD_MEM;
                        mem_rd_nxt = 1'b1;
                    end
                end else if (hit) begin
                    // forward only a whole, non-semaphore newest write
                    if (full_cov && !yng.sem && !yng.fence) begin // [RQ1] [RQ2] [RQ15] [RQ14]
                        for (int b = 0; b < `SBF_BEW; b++) begin
                            merged[b*8 +: 8] = ld_r.be[b] ? yng.wr.data[b*8 +: 8] : 8'h00;
                        end
                        rsp_valid_nxt = 1'b1;
                        rsp_data_nxt  = merged;
                        rsp_fwd_nxt   = 1'b1;
                        st_nxt        = sbf_pkg::SBF_LD_IDLE;
                    end
                end else begin
                    // no same-address write: pass earlier writes
                    st_nxt     = sbf_pkg::SBF_LD_MEM; // [RQ4] [RQ11]
                    mem_rd_nxt = 1'b1;
                end
            end
            sbf_pkg::SBF_LD_MEM: begin
                if (mem_rd_r && i_mem_rd_ack) begin
                    mem_rd_nxt    = 1'b0;
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = i_mem_rd_data;
                    rsp_fwd_nxt   = 1'b0;
                    st_nxt        = sbf_pkg::SBF_LD_IDLE;
                end
            end
            default: begin
                st_nxt = sbf_pkg::SBF_LD_IDLE;
            end
        endcase

        // a held read blocks every later request
        req_ready_nxt   = (st_nxt == sbf_pkg::SBF_LD_IDLE) &&
                          (count_nxt < CW'(DEPTH)); // [RQ10]
        drain_valid_nxt = (count_nxt != '0);
        drain_nxt       = ent_nxt[head_nxt].wr;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                ent_r[i] <= '0;
            end
            head_r        <= '0;
            count_r       <= '0;
            st_r          <= sbf_pkg::SBF_LD_IDLE;
            ld_r          <= '0;
            bar_wait_r    <= 1'b0;
            req_ready_r   <= 1'b0;
            rsp_valid_r   <= 1'b0;
            rsp_data_r    <= '0;
            rsp_fwd_r     <= 1'b0;
            bar_done_r    <= 1'b0;
            mem_rd_r      <= 1'b0;
            drain_valid_r <= 1'b0;
            drain_r       <= '0;
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                ent_r[i] <= ent_nxt[i];
            end
            head_r        <= head_nxt;
            count_r       <= count_nxt;
            st_r          <= st_nxt;
            ld_r          <= ld_nxt;
            bar_wait_r    <= bar_wait_nxt;
            req_ready_r   <= req_ready_nxt;
            rsp_valid_r   <= rsp_valid_nxt;
            rsp_data_r    <= rsp_data_nxt;
            rsp_fwd_r     <= rsp_fwd_nxt;
            bar_done_r    <= bar_done_nxt;
            mem_rd_r      <= mem_rd_nxt;
            drain_valid_r <= drain_valid_nxt;
            drain_r       <= drain_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_req_ready    = req_ready_r;
    assign o_rsp_valid    = rsp_valid_r;
    assign o_rsp_data     = rsp_data_r;
    assign o_rsp_fwd      = rsp_fwd_r;
    assign o_bar_done     = bar_done_r;
    assign o_mem_rd_valid = mem_rd_r;
    assign o_mem_rd_addr  = ld_r.addr;
    assign o_drain_valid  = drain_valid_r;
    assign o_drain        = drain_r;

endmodule

`default_nettype wire

/* sbf_cfg.svh */
// constants for the store buffer with local forwarding
`ifndef SBF_CFG_SVH
`define SBF_CFG_SVH

`define SBF_AW      32
`define SBF_DW      64
`define SBF_BEW     8
`define SBF_LANE_LSB 3
`define SBF_DEPTH   4

`endif

/* sbf_pkg.sv */
// types for the store buffer with local forwarding
`default_nettype none
`include "sbf_cfg.svh"
package sbf_pkg;

    typedef enum logic [2:0] {
        SBF_UNORDERED_WRITE,
        SBF_RELEASE_WRITE,
        SBF_SEMAPHORE_WRITE,
        SBF_UNORDERED_READ,
        SBF_ACQUIRE_READ,
        SBF_SEMAPHORE_READ,
        SBF_ORDERING_BARRIER
    } sbf_op_e;

    typedef struct packed {
        sbf_op_e                 op;
        logic [`SBF_AW-1:0]      addr;
        logic [`SBF_DW-1:0]      data;
        logic [`SBF_BEW-1:0]     be;
    } sbf_req_s;

    typedef struct packed {
        logic [`SBF_AW-1:0]      addr;
        logic [`SBF_DW-1:0]      data;
        logic [`SBF_BEW-1:0]     be;
    } sbf_write_s;

    typedef struct packed {
        logic                    vld;
        logic                    sem;
        logic                    fence;
        sbf_write_s              wr;
    } sbf_entry_s;

    typedef enum logic [1:0] {
        SBF_LD_IDLE,
        SBF_LD_HOLD,
        SBF_LD_MEM
    } sbf_ld_state_e;

endpackage

`default_nettype wire

/* sbf_store_buffer_sva.sv */
// assertion checker for the store buffer ports
`timescale 1ns/100ps
`default_nettype none
`include "sbf_cfg.svh"
module sbf_store_buffer_chk #(
    parameter int DEPTH = `SBF_DEPTH
) (
    // clock and reset
    input wire logic                i_sys_clk,
    input wire logic                i_rst_n,
    // request side
    input wire logic                i_req_valid,
    input wire sbf_pkg::sbf_req_s   i_req,
    input wire logic                o_req_ready,
    input wire logic                o_rsp_valid,
    input wire logic                o_rsp_fwd,
    input wire logic                o_bar_done,
    // far side
    input wire logic                o_mem_rd_valid,
    input wire logic [`SBF_AW-1:0]  o_mem_rd_addr,
    input wire logic                i_mem_rd_ack,
    input wire logic                o_drain_valid,
    input wire sbf_pkg::sbf_write_s o_drain,
    input wire logic                i_drain_ack
);
    logic       tk, tk_rd, dr, sem_r, sem_nxt;
    logic [7:0] cnt_r, cnt_nxt, need_r, need_nxt;
    ////////////////////////////////////////////////////////////////////////
    // pending semaphore read and entries ahead of a barrier
    always_comb begin
        tk = i_req_valid && o_req_ready;
        tk_rd = tk && i_req.op inside {[sbf_pkg::SBF_UNORDERED_READ:sbf_pkg::SBF_SEMAPHORE_READ]};
        dr = o_drain_valid && i_drain_ack;
        sem_nxt = (tk && i_req.op == sbf_pkg::SBF_SEMAPHORE_READ) ? 1'b1 : (o_rsp_valid ? 1'b0 : sem_r);
        cnt_nxt = cnt_r + 8'((tk && i_req.op <= sbf_pkg::SBF_SEMAPHORE_WRITE)) - 8'(dr);
        need_nxt = need_r - 8'(dr && need_r != 8'h0);
        if (tk && i_req.op == sbf_pkg::SBF_ORDERING_BARRIER) begin
            need_nxt = cnt_r - 8'(dr);
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sem_r <= 1'b0;
            cnt_r <= 8'h0;
            need_r <= 8'h0;
        end else begin
            sem_r <= sem_nxt;
            cnt_r <= cnt_nxt;
            need_r <= need_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    property p_rd_block;
        tk_rd |=> !o_req_ready;
    endproperty
    property p_rd_ans;
        tk_rd |=> !o_rsp_valid ##[1:1000] o_rsp_valid;
    endproperty
    property p_mem_hold;
        o_mem_rd_valid && !i_mem_rd_ack |=> o_mem_rd_valid && $stable(o_mem_rd_addr);
    endproperty
    property p_mem_rsp;
        o_mem_rd_valid && i_mem_rd_ack |=> o_rsp_valid && !o_rsp_fwd && !o_mem_rd_valid;
    endproperty
    property p_drn_hold;
        o_drain_valid && !i_drain_ack |=> o_drain_valid && $stable(o_drain);
    endproperty
    property p_sem_fwd;
        o_rsp_valid && sem_r |-> !o_rsp_fwd;
    endproperty
    property p_bar_done;
        o_bar_done |-> need_r == 8'h0;
    endproperty
    property p_bar_fwd;
        o_rsp_valid && o_rsp_fwd |-> need_r == 8'h0;
    endproperty
    a_rd_block: assert property (p_rd_block) else $error("request taken while read held");
    a_rd_ans: assert property (p_rd_ans) else $error("read answer timing wrong");
    a_mem_hold: assert property (p_mem_hold) else $error("memory read dropped early");
    a_mem_rsp: assert property (p_mem_rsp) else $error("memory answer missing");
    a_drn_hold: assert property (p_drn_hold) else $error("drain offer changed early");
    a_sem_fwd: assert property (p_sem_fwd) else $error("semaphore read forwarded");
    a_bar_done: assert property (p_bar_done) else $error("barrier done before drain");
    a_bar_fwd: assert property (p_bar_fwd) else $error("forward across barrier");
    c_fwd: cover property (o_rsp_valid && o_rsp_fwd);
    c_mem: cover property (o_rsp_valid && !o_rsp_fwd);
    c_bar: cover property (o_bar_done);
endmodule
bind sbf_store_buffer sbf_store_buffer_chk #(.DEPTH(DEPTH)) u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
    .o_rsp_fwd(o_rsp_fwd), .o_bar_done(o_bar_done), .o_mem_rd_valid(o_mem_rd_valid),
    .o_mem_rd_addr(o_mem_rd_addr), .i_mem_rd_ack(i_mem_rd_ack), .o_drain_valid(o_drain_valid),
    .o_drain(o_drain), .i_drain_ack(i_drain_ack));
`default_nettype wire

/* sbf_far_model.sv */
// coherence domain model: memory reads and write drain
`timescale 1ns/100ps
`default_nettype none
`include "sbf_cfg.svh"
module sbf_far_model (
    // clock, reset, drain stall
    input wire logic                i_clk,
    input wire logic                i_rst_n,
    input wire logic                i_stall,
    // read and drain ports
    input wire logic                i_rd_valid,
    input wire logic [`SBF_AW-1:0]  i_rd_addr,
    output logic                    o_rd_ack,
    output logic [`SBF_DW-1:0]      o_rd_data,
    input wire logic                i_drn_valid,
    input wire sbf_pkg::sbf_write_s i_drn,
    output logic                    o_drn_ack
);
    logic [`SBF_DW-1:0] mem [logic [28:0]];
    logic [`SBF_DW-1:0] q_r, w;
    assign o_drn_ack = i_drn_valid && !i_stall;
    // data line never holds a stale value outside the ack cycle
    assign o_rd_data = o_rd_ack ? q_r : ~q_r;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_ack <= 1'b0;
            q_r <= '0;
        end else begin
            o_rd_ack <= i_rd_valid && !o_rd_ack;
            if (i_rd_valid && !o_rd_ack) begin
                q_r <= mem.exists(i_rd_addr[31:3]) ? mem[i_rd_addr[31:3]] : '0;
            end
            if (o_drn_ack) begin
                w = mem.exists(i_drn.addr[31:3]) ? mem[i_drn.addr[31:3]] : '0;
                for (int b = 0; b < 8; b++) begin
                    if (i_drn.be[b]) w[8*b+:8] = i_drn.data[8*b+:8];
                end
                mem[i_drn.addr[31:3]] = w;
            end
        end
    end
endmodule
`default_nettype wire

/* sbf_store_buffer_bench.sv */
// self-checking bench for the store buffer
`timescale 1ns/100ps
`default_nettype none
`include "sbf_cfg.svh"
module sbf_store_buffer_bench;
    logic                clk, rst_n, req_valid, stall, ready, rsp_valid, fwd, bar_done;
    logic                rd_valid, rd_ack, drn_valid, drn_ack;
    sbf_pkg::sbf_req_s   req;
    logic [`SBF_DW-1:0]  rsp_data, rd_data;
    logic [`SBF_AW-1:0]  rd_addr;
    sbf_pkg::sbf_write_s drn;
    logic [63:0]         shadow [logic [28:0]];
    logic [65:0]         expq [$];
    logic [65:0]         e;
    int                  n_errors, num_checks, n_bar;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    sbf_store_buffer u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_req_valid(req_valid), .i_req(req),
        .o_req_ready(ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_rsp_fwd(fwd),
        .o_bar_done(bar_done), .o_mem_rd_valid(rd_valid), .o_mem_rd_addr(rd_addr), .i_mem_rd_ack(rd_ack),
        .i_mem_rd_data(rd_data), .o_drain_valid(drn_valid), .o_drain(drn), .i_drain_ack(drn_ack));
    sbf_far_model u_far (.i_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_rd_valid(rd_valid),
        .i_rd_addr(rd_addr), .o_rd_ack(rd_ack), .o_rd_data(rd_data), .i_drn_valid(drn_valid),
        .i_drn(drn), .o_drn_ack(drn_ack));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [63:0] s, input logic [63:0] x);
        num_checks++;
        if (s !== x) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic complete_run;
        if (n_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic send(input sbf_pkg::sbf_op_e op, input logic [31:0] a, input logic [63:0] d,
                        input logic [7:0] be);
        logic rdy;
        int   n;
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req = '{op, a, d, be};
        n = 0;
        do begin
            rdy = ready;
            @(posedge clk);
            #1;
            n++;
        end while (rdy !== 1'b1 && n < 3000);
        req_valid = 1'b0;
    endtask
    // program-order value kept per word
    task automatic wr(input sbf_pkg::sbf_op_e op, input logic [31:0] a, input logic [7:0] be);
        logic [63:0] w, d;
        d = {$urandom, $urandom};
        w = shadow.exists(a[31:3]) ? shadow[a[31:3]] : 64'h0;
        for (int b = 0; b < 8; b++) begin
            if (be[b]) w[8*b+:8] = d[8*b+:8];
        end
        shadow[a[31:3]] = w;
        send(op, a, d, be);
    endtask
    task automatic rd(input sbf_pkg::sbf_op_e op, input logic [31:0] a, input logic c, input logic f);
        expq.push_back({c, f, shadow.exists(a[31:3]) ? shadow[a[31:3]] : 64'h0});
        send(op, a, 64'h0, 8'hff);
    endtask
    task automatic go(input logic v);
        repeat (20) @(posedge clk);
        #1;
        stall = v;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (bar_done === 1'b1) n_bar++;
        if (rsp_valid === 1'b1) begin
            check("rsp_expected", expq.size() > 0, 1'b1);
            e = (expq.size() > 0) ? expq.pop_front() : 66'h0;
            check("rsp_data", rsp_data, e[63:0]);
            if (e[65]) check("rsp_fwd", fwd, e[64]);
        end
    end
    initial begin
        #(50 * 20000);
        n_errors++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        stall = 1'b1;
        req = '0;
        void'($urandom(41));
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        wr(sbf_pkg::SBF_RELEASE_WRITE, 32'h100, 8'hff);
        rd(sbf_pkg::SBF_ACQUIRE_READ, 32'h100, 1'b1, 1'b1);
        wr(sbf_pkg::SBF_UNORDERED_WRITE, 32'h108, 8'hff);
        wr(sbf_pkg::SBF_UNORDERED_WRITE, 32'h108, 8'hff);
        rd(sbf_pkg::SBF_UNORDERED_READ, 32'h108, 1'b1, 1'b1);
        rd(sbf_pkg::SBF_UNORDERED_READ, 32'h200, 1'b1, 1'b0);
        go(1'b0);
        go(1'b1);
        wr(sbf_pkg::SBF_SEMAPHORE_WRITE, 32'h300, 8'hff);
        rd(sbf_pkg::SBF_UNORDERED_READ, 32'h300, 1'b1, 1'b0);
        go(1'b0);
        go(1'b1);
        wr(sbf_pkg::SBF_UNORDERED_WRITE, 32'h308, 8'hff);
        rd(sbf_pkg::SBF_SEMAPHORE_READ, 32'h308, 1'b1, 1'b0);
        go(1'b0);
        go(1'b1);
        wr(sbf_pkg::SBF_UNORDERED_WRITE, 32'h400, 8'hff);
        send(sbf_pkg::SBF_ORDERING_BARRIER, 32'h0, 64'h0, 8'h0);
        rd(sbf_pkg::SBF_ACQUIRE_READ, 32'h400, 1'b1, 1'b0);
        go(1'b0);
        go(1'b1);
        wr(sbf_pkg::SBF_UNORDERED_WRITE, 32'h500, 8'hff);
        wr(sbf_pkg::SBF_UNORDERED_WRITE, 32'h500, 8'h0f);
        rd(sbf_pkg::SBF_UNORDERED_READ, 32'h500, 1'b1, 1'b0);
        go(1'b0);
        repeat (40) begin
            if ($urandom_range(1)) wr(sbf_pkg::SBF_UNORDERED_WRITE, 32'h600 + 32'($urandom_range(3) * 8), 8'hff);
            else rd(sbf_pkg::SBF_UNORDERED_READ, 32'h600 + 32'($urandom_range(3) * 8), 1'b0, 1'b0);
        end
        go(1'b0);
        check("bar_done", n_bar, 1);
        check("pending", expq.size(), 0);
        complete_run();
    end
endmodule
`default_nettype wire
